// [logic/dpw_map.svh]
// constants of the converter write port host controller
`ifndef DPW_MAP_SVH
`define DPW_MAP_SVH
`define DPW_WORD_W 12
`define DPW_TOP_BIT 11
`define DPW_CLK_NS 20
`define DPW_STROBE_MIN_NS 40
`define DPW_WAIT_STATES 1
`define DPW_PORT_NUM 3'h0
`define DPW_PORT_W 3
`define DPW_CNT_W 4
`define DPW_WORD_RESET 12'h000
`define DPW_CNT_ZERO 4'h0
`define DPW_CNT_ONE 4'h1
`endif

// [logic/dpw_pkg.sv]
// types of the converter write port host controller
`include "dpw_map.svh"
package dpw_pkg;
    // one-hot write sequence states
    typedef enum logic [3:0] {
        IDLE = 4'h1,
        SETUP = 4'h2,
        STROBE = 4'h4,
        HOLD = 4'h8
    } dpw_state_e;

    // whole state of the controller
    typedef struct packed {
        dpw_state_e state;
        logic [`DPW_CNT_W-1:0] cnt;
        logic [`DPW_CNT_W-1:0] lowCnt;
        logic [`DPW_WORD_W-1:0] word;
        logic [`DPW_WORD_W-1:0] raw;
        logic twos;
        logic strobeN;
        logic ackN;
        logic busy;
        logic done;
    } dpw_state_s;
endpackage : dpw_pkg

// [logic/dpw_code_map.sv]
// maps a host data word onto the converter's input coding
`timescale 1ns/10ps
`default_nettype none
`include "dpw_map.svh"
module dpw_code_map #(
    parameter int W = `DPW_WORD_W
) (
    input wire logic [W-1:0] hostWord,
    input wire logic twosComp,
    output logic [W-1:0] inputWordBits
);
    // ===================================================
    // coding
    // positive-true bits pass straight; only the top bit flips for twos
    // complement, which turns it into offset binary
    always_comb begin
        inputWordBits = hostWord; // see RULE4 see RULE5 see RULE6
        if (twosComp) begin
            inputWordBits[W-1] = ~hostWord[W-1]; // see RULE7
        end
    end
endmodule : dpw_code_map
`default_nettype wire

// [logic/dpw_host_port.sv]
// host-side controller driving the converter's parallel write port
`timescale 1ns/10ps
`default_nettype none
`include "dpw_map.svh"
// How it works
// RULE1: converter latches one whole 12-bit word
// RULE2: strobe held low at least 40 ns
// RULE3: data stays valid through strobe rising edge
// RULE4: data bits are positive-true binary
// RULE5: unipolar word is straight binary
// RULE6: bipolar word is offset binary
// RULE7: twos complement data gets top bit inverted
// RULE8: undriven converter inputs read as zero
// RULE9: strobe only on writes to port address
// RULE10: acknowledge ends the bus cycle
// RULE11: port number decode gates the strobe
// RULE12: io space select enables the decode
// RULE13: decode combines with write and strobe
// RULE14: decode only while space select asserted
// RULE15: write strobe ORed with decode forms strobe
// RULE16: acknowledge held low, strobe extended one cycle
// RULE17: wait flop sets, acknowledge rises, cycle ends
// RULE18: exactly one wait state per write
// RULE19: wait states set by host speed parameter
// RULE20: converter keeps last word between strobes
module dpw_host_port #(
    parameter int WAIT_ST = `DPW_WAIT_STATES,
    parameter logic [`DPW_PORT_W-1:0] PORT_NUM = `DPW_PORT_NUM
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wrReq,
    input wire logic [`DPW_WORD_W-1:0] wrData,
    input wire logic [`DPW_PORT_W-1:0] portNumberLines,
    input wire logic ioSpaceSelect,
    input wire logic twosComp,
    output logic wrBusy,
    output logic wrDone,
    output logic [`DPW_WORD_W-1:0] inputWordBits,
    output logic chipSelectN,
    output logic transferAcknowledgeN
);
    // ===================================================
    // timing
    // least strobe time rounds up to whole clock cycles
    localparam int BUS_STROBE_N_CYC =
        (`DPW_STROBE_MIN_NS + `DPW_CLK_NS - 1) / `DPW_CLK_NS;
    localparam int BUS_STROBE_N_TOTAL = BUS_STROBE_N_CYC + WAIT_ST; // see RULE19
    localparam logic [`DPW_CNT_W-1:0] CNT_LOAD =
        `DPW_CNT_W'(BUS_STROBE_N_TOTAL - 1);

    dpw_pkg::dpw_state_s st_ff;
    dpw_pkg::dpw_state_s nxt_st;
    logic [`DPW_WORD_W-1:0] mappedWord;
    logic portHit;

    // ===================================================
    // coding of the outgoing word
    dpw_code_map #(
        .W(`DPW_WORD_W)
    ) u_code_map (
        .hostWord(wrData),
        .twosComp(twosComp),
        .inputWordBits(mappedWord)
    );

    // decode runs only for io space cycles at our port number
    assign portHit = ioSpaceSelect && // see RULE12 see RULE14
        (portNumberLines == PORT_NUM); // see RULE11

    // ===================================================
    // write sequence: setup, strobe low, hold, done
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        // strobe low time counter kept for the checks below
        nxt_st.lowCnt = st_ff.strobeN ? `DPW_CNT_ZERO
            : st_ff.lowCnt + `DPW_CNT_ONE;
        case (st_ff.state)
            dpw_pkg::IDLE: begin
                if (wrReq && portHit) begin
                    nxt_st.state = dpw_pkg::SETUP;
                    nxt_st.word = mappedWord; // see RULE1 see RULE7
                    nxt_st.raw = wrData;
                    nxt_st.twos = twosComp;
                    nxt_st.busy = 1'b1;
                    nxt_st.ackN = 1'b0; // see RULE16
                end else if (wrReq) begin
                    // other port or memory space: no strobe at all
                    nxt_st.done = 1'b1; // see RULE9
                end
            end
            dpw_pkg::SETUP: begin
                // data settled one cycle before the strobe falls
                nxt_st.state = dpw_pkg::STROBE;
                nxt_st.strobeN = 1'b0; // see RULE13 see RULE15
                nxt_st.cnt = CNT_LOAD;
            end
            dpw_pkg::STROBE: begin
                if (st_ff.cnt == `DPW_CNT_ZERO) begin
                    // rising edge latches the word; ack rises with it
                    nxt_st.state = dpw_pkg::HOLD;
                    nxt_st.strobeN = 1'b1; // see RULE3 see RULE2
                    nxt_st.ackN = 1'b1; // see RULE17 see RULE10
                end else begin
                    nxt_st.cnt = st_ff.cnt - `DPW_CNT_ONE; // see RULE18
                end
            end
            dpw_pkg::HOLD: begin
                // word stays on the pins after the edge (hold time)
                nxt_st.state = dpw_pkg::IDLE;
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
            default: begin
                nxt_st.state = dpw_pkg::IDLE;
                nxt_st.strobeN = 1'b1;
                nxt_st.ackN = 1'b1;
                nxt_st.busy = 1'b0;
            end
        endcase
    end

    // ===================================================
    // state register
    // word pins are driven to zero from reset, never left floating
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_ff.state <= dpw_pkg::IDLE;
            st_ff.cnt <= `DPW_CNT_ZERO;
            st_ff.lowCnt <= `DPW_CNT_ZERO;
            st_ff.word <= `DPW_WORD_RESET; // see RULE8
            st_ff.raw <= `DPW_WORD_RESET;
            st_ff.twos <= 1'b0;
            st_ff.strobeN <= 1'b1;
            st_ff.ackN <= 1'b1;
            st_ff.busy <= 1'b0;
            st_ff.done <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ===================================================
    // outputs, all straight from the state register
    assign wrBusy = st_ff.busy;
    assign wrDone = st_ff.done;
    assign inputWordBits = st_ff.word; // see RULE20
    assign chipSelectN = st_ff.strobeN;
    assign transferAcknowledgeN = st_ff.ackN;

    // ===================================================
    // checks
    strobe_min_width_a: assert property ( // see RULE2
        @(posedge clk_sys) disable iff (reset)
        $fell(chipSelectN) |-> !chipSelectN ##1 !chipSelectN)
        else $error("strobe low shorter than two cycles");

    strobe_total_len_a: assert property ( // see RULE16
        @(posedge clk_sys) disable iff (reset)
        $rose(chipSelectN) |-> st_ff.lowCnt == `DPW_CNT_W'(BUS_STROBE_N_TOTAL))
        else $error("strobe low length not base plus wait states");

    data_hold_edge_a: assert property ( // see RULE3
        @(posedge clk_sys) disable iff (reset)
        !chipSelectN |=> $stable(inputWordBits))
        else $error("word changed while strobe low or at its rise");

    word_kept_idle_a: assert property ( // see RULE20
        @(posedge clk_sys) disable iff (reset)
        // only a taken request may load a new word onto the pins
        !((st_ff.state == dpw_pkg::IDLE) && wrReq && portHit)
            |=> $stable(inputWordBits))
        else $error("word changed outside a write");

    top_bit_flip_a: assert property ( // see RULE7
        @(posedge clk_sys) disable iff (reset)
        !chipSelectN |-> inputWordBits[`DPW_TOP_BIT] ==
            (st_ff.raw[`DPW_TOP_BIT] ^ st_ff.twos))
        else $error("top bit coding wrong");

    ack_low_strobe_a: assert property ( // see RULE16
        @(posedge clk_sys) disable iff (reset)
        $fell(chipSelectN) |-> !transferAcknowledgeN
            throughout (!chipSelectN [*2]))
        else $error("acknowledge not low during strobe");

    ack_rise_edge_a: assert property ( // see RULE17
        @(posedge clk_sys) disable iff (reset)
        $rose(chipSelectN) |-> $rose(transferAcknowledgeN)
            ##1 (wrDone && !wrBusy))
        else $error("acknowledge or done late at strobe rise");

    no_strobe_miss_a: assert property ( // see RULE9
        @(posedge clk_sys) disable iff (reset)
        (st_ff.state == dpw_pkg::IDLE) && wrReq && !portHit
            |=> chipSelectN && wrDone ##1 chipSelectN)
        else $error("strobe for a foreign address");

    req_to_strobe_a: assert property ( // see RULE11
        @(posedge clk_sys) disable iff (reset)
        (st_ff.state == dpw_pkg::IDLE) && wrReq && portHit
            |=> chipSelectN ##1 !chipSelectN)
        else $error("strobe not issued two cycles after request");

    ack_setup_wait_a: assert property ( // see RULE16
        @(posedge clk_sys) disable iff (reset)
        $rose(wrBusy) |-> !transferAcknowledgeN && chipSelectN
            ##1 $fell(chipSelectN))
        else $error("acknowledge not low at setup or strobe late");

    strobe_in_write_a: assert property ( // see RULE9
        @(posedge clk_sys) disable iff (reset)
        !chipSelectN |-> wrBusy && !transferAcknowledgeN)
        else $error("strobe low outside a wait-held write");

    ack_in_write_a: assert property ( // see RULE10
        @(posedge clk_sys) disable iff (reset)
        !transferAcknowledgeN |-> wrBusy)
        else $error("acknowledge held low outside a write");

    write_end_a: assert property ( // see RULE17
        @(posedge clk_sys) disable iff (reset)
        $fell(wrBusy) |-> wrDone && chipSelectN && transferAcknowledgeN)
        else $error("write ended with strobe or acknowledge low");

    strobe_gap_a: assert property ( // see RULE3
        @(posedge clk_sys) disable iff (reset)
        $rose(chipSelectN) |-> chipSelectN [*3])
        else $error("strobes closer than three high cycles");
endmodule : dpw_host_port
`default_nettype wire

// [logic/dpw_unused_never.sv]
// no content
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [testbench/dpw_conv_model.sv]
// converter input latch model for the host port bench
`timescale 1ns/10ps
`default_nettype none
`include "dpw_map.svh"
// ==========
// converter latch
module dpw_conv_model (
    input wire logic chipSelectN,
    input wire logic [`DPW_WORD_W-1:0] inputWordBits,
    output logic [`DPW_WORD_W-1:0] latchedWord,
    output logic [7:0] strobeCount,
    output logic [15:0] lowNs
);
    realtime fallAt;
    // open pins read as zero before any write
    initial begin
        latchedWord = 12'h000;
        strobeCount = 8'h00;
        lowNs = 16'h0000;
        fallAt = 0.0;
    end
    // remember the strobe fall to time the pulse
    always @(negedge chipSelectN) begin
        fallAt = $realtime;
    end
    // whole word taken on the rise, held until the next one
    always @(posedge chipSelectN) begin
        if (fallAt > 0.0) begin // reset rise from unknown is no write
            latchedWord = inputWordBits;
            strobeCount = strobeCount + 8'h01;
            lowNs = 16'(int'($realtime - fallAt));
        end
    end
endmodule : dpw_conv_model
`default_nettype wire

// [testbench/dpw_host_port_tb.sv]
// self-checking bench for the converter write port controller
`timescale 1ns/10ps
`default_nettype none
`include "dpw_map.svh"
// ==========
// bench top
module dpw_host_port_tb;
    localparam logic [2:0] PORT = 3'h2;
    logic clk_sys, reset, wrReq, ioSpaceSelect, twosComp;
    logic [11:0] wrData, inputWordBits, latchedWord;
    logic [2:0] portNumberLines;
    logic wrBusy, wrDone, chipSelectN, transferAcknowledgeN;
    logic [7:0] strobeCount;
    logic [15:0] lowNs;
    int errors = 0, compares = 0, cycles = 0, csLow, ackLow, busyHi;
    dpw_host_port #(.WAIT_ST(1), .PORT_NUM(PORT)) dut (.clk_sys(clk_sys),
        .reset(reset), .wrReq(wrReq), .wrData(wrData),
        .portNumberLines(portNumberLines), .ioSpaceSelect(ioSpaceSelect),
        .twosComp(twosComp), .wrBusy(wrBusy), .wrDone(wrDone),
        .inputWordBits(inputWordBits), .chipSelectN(chipSelectN),
        .transferAcknowledgeN(transferAcknowledgeN));
    dpw_conv_model conv (.chipSelectN(chipSelectN),
        .inputWordBits(inputWordBits), .latchedWord(latchedWord),
        .strobeCount(strobeCount), .lowNs(lowNs));
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // one request, then count strobe and wait cycles until done
    task automatic write(input logic [11:0] d, input logic [2:0] p,
                         input logic io, input logic tc);
        int n;
        @(posedge clk_sys);
        wrData <= d;
        portNumberLines <= p;
        ioSpaceSelect <= io;
        twosComp <= tc;
        wrReq <= 1'b1;
        @(posedge clk_sys);
        wrReq <= 1'b0;
        csLow = 0;
        ackLow = 0;
        busyHi = 0;
        n = 0;
        do begin
            #1;
            csLow += int'(chipSelectN === 1'b0);
            ackLow += int'(transferAcknowledgeN === 1'b0);
            busyHi += int'(wrBusy === 1'b1);
            n++;
            if (wrDone !== 1'b1) @(posedge clk_sys);
        end while (wrDone !== 1'b1 && n < 20);
        chk("done", 16'h0001, {15'h0, wrDone});
    endtask : write
    task automatic hit(input logic [11:0] d, input logic tc,
                       input logic [11:0] pins);
        logic [7:0] cnt;
        cnt = strobeCount;
        write(d, PORT, 1'b1, tc);
        chk("pins", {4'h0, pins}, {4'h0, inputWordBits});
        chk("latched", {4'h0, pins}, {4'h0, latchedWord});
        chk("strobes", 16'(cnt + 8'h01), {8'h0, strobeCount});
        chk("low cycles", 16'h0003, 16'(csLow));
        chk("ack cycles", 16'h0004, 16'(ackLow));
        chk("width ok", 16'h0001, {15'h0, lowNs >= 16'h0028});
        chk("busy", 16'h0000, {15'h0, wrBusy});
        chk("busy cycles", 16'h0005, 16'(busyHi));
        $display("write %h done", d);
    endtask : hit
    // access not ours: no strobe, pins and latch untouched
    task automatic miss(input logic [2:0] p, input logic io);
        logic [7:0] cnt;
        logic [11:0] w;
        cnt = strobeCount;
        w = latchedWord;
        write(12'h5a5, p, io, 1'b0);
        chk("no strobe", 16'h0000, 16'(csLow + ackLow));
        chk("count", {8'h0, cnt}, {8'h0, strobeCount});
        chk("kept", {4'h0, w}, {4'h0, latchedWord});
        chk("pins kept", {4'h0, w}, {4'h0, inputWordBits});
        chk("no busy", 16'h0000, 16'(busyHi));
        $display("ignored access done");
    endtask : miss
    // clock, timeout ceiling
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            conclude();
        end
    end
    // ==========
    // main sequence
    initial begin
        reset = 1'b1;
        wrReq = 1'b0;
        wrData = 12'h000;
        portNumberLines = 3'h0;
        ioSpaceSelect = 1'b0;
        twosComp = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("reset pins", 16'h0003, {14'h0, chipSelectN,
            transferAcknowledgeN});
        chk("reset word", 16'h0000, {2'h0, wrBusy, wrDone, inputWordBits});
        $display("reset done");
        hit(12'hfff, 1'b0, 12'hfff);
        hit(12'h000, 1'b0, 12'h000);
        hit(12'h800, 1'b0, 12'h800);
        hit(12'h000, 1'b1, 12'h800);
        hit(12'h7ff, 1'b1, 12'hfff);
        miss(PORT, 1'b0);
        miss(3'h5, 1'b1);
        hit(12'h123, 1'b0, 12'h123);
        hit(12'h456, 1'b0, 12'h456);
        conclude();
    end
endmodule : dpw_host_port_tb
`default_nettype wire
